// [rtl/ccm_master.sv]
// Bus master that writes, points at and reads the charge-counter registers.
// Assumes open-drain SDA/SCL with external pull-ups; enables are low-active.
//
// Notes on behaviour
// - Bus clock never faster than 400 kHz.
// - Start: data falls while clock is high.
// - Stop: data rises while clock is high.
// - Eight data bits then one acknowledge clock per frame.
// - Bytes sent most significant bit first.
// - Master makes every clock pulse, acknowledge included.
// - On read, slave transmits; master may acknowledge or not.
// - Receiver holds data low through acknowledge high phase.
// - Transmitter releases data during acknowledge clock.
// - Direction bit zero writes, one reads; C8 and C9.
// - First byte after write address loads subaddress pointer.
// - Write: master transmits; read: roles swap after address.
// - Every transaction begins with a start.
`timescale 1ns/1ns
module ccm_master (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire ccm_pkg::ccm_cmd_e cmd_op,
  input wire logic [7:0] cmd_sub,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  // ==========================================================
  // Input synchronisers
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
    end
  end

  // ==========================================================
  // Glitch filters
  // A change is believed only after FLT_CYC equal samples, at the cost
  // of that much extra delay before the sample point.
  logic [1:0] line_s;
  logic [1:0] line_f;
  logic scl_in;
  logic sda_in;
  assign line_s = {scl_s_q[1], sda_s_q[1]};
  for (genvar gi = 0; gi < 2; gi++) begin : g_flt
    logic [ccm_pkg::FLT_W-1:0] cnt_q;
    logic lvl_q;
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        cnt_q <= '0;
        lvl_q <= 1'b1;
      end else if (line_s[gi] == lvl_q) begin
        cnt_q <= '0;
      end else if (cnt_q == ccm_pkg::FLT_W'(ccm_pkg::FLT_CYC - 1)) begin
        cnt_q <= '0;
        lvl_q <= line_s[gi];
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
    assign line_f[gi] = lvl_q;
  end
  assign scl_in = line_f[1];
  assign sda_in = line_f[0];

  // ==========================================================
  // Quarter-period tick
  logic [ccm_pkg::QTR_W-1:0] qcnt_q;
  logic tick;
  assign tick = (qcnt_q == ccm_pkg::QTR_W'(ccm_pkg::QTR_CYC - 1));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      qcnt_q <= '0;
    end else if (tick) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= qcnt_q + 1'b1;
    end
  end

  // ==========================================================
  // Bus-free watch
  logic free_q;
  // Start only launched on a quiet bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      free_q <= 1'b0;
    end else if (!scl_in || !sda_in) begin
      free_q <= 1'b0;
    end else if (tick) begin
      free_q <= 1'b1;
    end
  end

  // ==========================================================
  // Sequencer
  ccm_pkg::ccm_state_e st_q;
  ccm_pkg::ccm_cmd_e op_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [1:0] nbytes_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic [7:0] sub_q;
  logic [7:0] dat_q;
  logic nack_q;
  logic scl_q;
  logic sda_q;
  logic rd_byte;
  logic [7:0] next_tx;
  logic rw_bit;
  logic [7:0] addr_byte;

  assign cmd_ready = (st_q == ccm_pkg::CCM_IDLE) && free_q;
  // Read data byte is byte 1 of a read command
  assign rd_byte = (op_q == ccm_pkg::CCM_CMD_READ) && (byte_q == 2'h1);
  // Seven-bit address, direction in the low bit
  assign rw_bit = (op_q == ccm_pkg::CCM_CMD_READ) ? ccm_pkg::RW_READ
                                                  : ccm_pkg::RW_WRITE;
  assign addr_byte = {ccm_pkg::DEV_ADDR, rw_bit};

  always_comb begin
    next_tx = 8'hff;
    if (byte_q == 2'h0) begin
      next_tx = sub_q;
    end else begin
      next_tx = dat_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ccm_pkg::CCM_IDLE;
      op_q <= ccm_pkg::CCM_CMD_WRITE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      nbytes_q <= 2'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      sub_q <= 8'h00;
      dat_q <= 8'h00;
      nack_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      case (st_q)
        ccm_pkg::CCM_IDLE: begin
          scl_q <= 1'b1;
          sda_q <= 1'b1;
          if (cmd_valid && free_q) begin
            op_q <= cmd_op;
            sub_q <= cmd_sub;
            dat_q <= cmd_data;
            nack_q <= 1'b0;
            ph_q <= 2'h0;
            st_q <= ccm_pkg::CCM_START;
          end
        end
        ccm_pkg::CCM_START: begin
          // Open with start; data falls, clock high
          if (tick) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == 2'h1) begin
              sda_q <= 1'b0;
            end else if (ph_q == 2'h3) begin
              scl_q <= 1'b0;
              bit_q <= 4'h0;
              byte_q <= 2'h0;
              ph_q <= 2'h0;
              sh_q <= addr_byte;
              nbytes_q <= (op_q == ccm_pkg::CCM_CMD_WRITE) ? 2'h2 :
                          2'h1;
              st_q <= ccm_pkg::CCM_BIT;
            end
          end
        end
        ccm_pkg::CCM_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 1'b1;
            case (ph_q)
              2'h0: begin
                if (bit_q < 4'(ccm_pkg::BYTE_BITS)) begin
                  // Release line when the slave transmits
                  sda_q <= rd_byte ? 1'b1 : sh_q[7];
                end else begin
                  // Master never acks; it releases data in every ack slot, read byte included
                  sda_q <= rd_byte ? 1'b1 : 1'b1;
                end
              end
              // Master raises clock; no stretch wait
              2'h1: scl_q <= 1'b1;
              2'h2: begin
                if (bit_q < 4'(ccm_pkg::BYTE_BITS)) begin
                  sh_q <= {sh_q[6:0], 1'b0};
                  rx_q <= {rx_q[6:0], sda_in};
                end else if (!rd_byte && sda_in) begin
                  nack_q <= 1'b1;
                end
              end
              default: begin
                scl_q <= 1'b0;
                if (bit_q == 4'(ccm_pkg::BYTE_BITS)) begin
                  bit_q <= 4'h0;
                  sh_q <= next_tx;
                  if (nack_q || byte_q == nbytes_q) begin
                    st_q <= ccm_pkg::CCM_STOP;
                  end else begin
                    byte_q <= byte_q + 1'b1;
                  end
                end else begin
                  bit_q <= bit_q + 1'b1;
                end
              end
            endcase
          end
        end
        ccm_pkg::CCM_STOP: begin
          // Stop commits written data in the slave
          if (tick) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == 2'h0) begin
              sda_q <= 1'b0;
            end else if (ph_q == 2'h1) begin
              scl_q <= 1'b1;
            end else if (ph_q == 2'h3) begin
              sda_q <= 1'b1;
              st_q <= ccm_pkg::CCM_DONE;
            end
          end
        end
        default: begin
          // Bus-free gap before the next command
          if (tick) begin
            st_q <= ccm_pkg::CCM_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Response
  logic done_tick;
  assign done_tick = (st_q == ccm_pkg::CCM_DONE) && tick;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_nack <= 1'b0;
    end else begin
      // Pulse lasts one cycle; data stands until the next pulse
      rsp_valid <= done_tick;
      if (done_tick) begin
        rsp_data <= rx_q;
        rsp_nack <= nack_q;
      end
    end
  end

  // ==========================================================
  // Open-drain pins: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = scl_q;
  assign sda_oe_n = sda_q;
endmodule : ccm_master

// [rtl/ccm_pkg.sv]
// Package for the two-wire bus master that drives the charge-counter port.
// Assumes a 250 MHz system clock and open-drain lines with pull-ups.
package ccm_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 250;
  // Fastest bus clock the slave accepts, in kHz
  localparam int BUS_KHZ_MAX = 400;
  // Quarter period of the bus clock, rounded up so the rate stays legal
  localparam int QTR_CYC = (CLK_MHZ * 1000 + 4 * BUS_KHZ_MAX - 1)
    / (4 * BUS_KHZ_MAX);
  localparam int QTR_W = 8;
  // Glitch filter length in clock cycles and its counter width
  localparam int FLT_CYC = 4;
  localparam int FLT_W = 3;
  // ==========================================================
  // Addressing
  localparam logic [6:0] DEV_ADDR = 7'h64;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam int BYTE_BITS = 8;
  // ==========================================================
  // Commands
  typedef enum logic [1:0] {
    CCM_CMD_WRITE,
    CCM_CMD_POINT,
    CCM_CMD_READ
  } ccm_cmd_e;
  typedef enum {
    CCM_IDLE, CCM_START, CCM_BIT, CCM_STOP, CCM_DONE
  } ccm_state_e;
endpackage : ccm_pkg

// [testbench/ccm_chk_props.sv]
// Checker for the bus master pins and frame content.
// Assumes binding onto ccm_master; open-drain lines with pull-ups.
`timescale 1ns/1ns
module ccm_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire ccm_pkg::ccm_cmd_e cmd_op,
  input wire logic [7:0] cmd_sub,
  input wire logic rsp_valid,
  input wire logic rsp_nack,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic scl_o,
  input wire logic sda_o
);
  // ==========================================================
  // Line edges and frame position
  logic scl_q, sda_q, rd_q;
  logic [15:0] per_q;
  logic [5:0] pul_q;
  logic [7:0] sh_q, sub_q;
  wire logic take = cmd_valid && cmd_ready;
  wire logic rise = scl_oe_n && !scl_q;
  wire logic strt = scl_oe_n && scl_q && sda_q && !sda_oe_n;
  wire logic stp = scl_oe_n && scl_q && !sda_q && sda_oe_n;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {scl_q, sda_q, per_q} <= {2'b11, 16'hffff};
      {pul_q, sh_q, sub_q, rd_q} <= 23'h000000;
    end else begin
      {scl_q, sda_q} <= {scl_oe_n, sda_oe_n};
      // Saturates so a long idle never wraps into a short period
      per_q <= rise ? 16'h0000 : per_q + {15'h0000, per_q != 16'hffff};
      pul_q <= strt ? 6'h00 : pul_q + {5'h00, rise};
      sh_q <= rise ? {sh_q[6:0], sda_oe_n} : sh_q;
      sub_q <= take ? cmd_sub : sub_q;
      rd_q <= take ? cmd_op == ccm_pkg::CCM_CMD_READ : rd_q;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rate; rise |-> per_q >= 16'd624; endproperty
  a_rate: assert property (p_rate) else $error("scl too fast");
  property p_start; take |-> ##[1:400] strt; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_stop; stp |-> ##[1:400] rsp_valid; endproperty
  a_stop: assert property (p_stop) else $error("no done");
  property p_frame; rsp_valid |-> pul_q inside {6'd10, 6'd19, 6'd28};
  endproperty
  a_frame: assert property (p_frame) else $error("clock count");
  property p_rdrel; rise && rd_q && pul_q inside {[6'd9:6'd17]}
    |-> sda_oe_n; endproperty
  a_rdrel: assert property (p_rdrel) else $error("read drive");
  property p_ackrel; rise && pul_q inside {6'd8, 6'd17, 6'd26}
    |-> sda_oe_n; endproperty
  a_ackrel: assert property (p_ackrel) else $error("ack drive");
  property p_addr; rise && pul_q == 6'd8
    |-> sh_q == {ccm_pkg::DEV_ADDR, rd_q}; endproperty
  a_addr: assert property (p_addr) else $error("address");
  property p_sub; rise && pul_q == 6'd17 && !rd_q |-> sh_q == sub_q;
  endproperty
  a_sub: assert property (p_sub) else $error("subaddress");
  property p_odrain; scl_o == 1'b0 && sda_o == 1'b0; endproperty
  a_odrain: assert property (p_odrain) else $error("pin high");
  c_wr: cover property (rsp_valid && pul_q == 6'd28);
  c_rd: cover property (rsp_valid && rd_q);
  c_nk: cover property (rsp_valid && rsp_nack);
endmodule : ccm_chk
bind ccm_master ccm_chk ccm_chk_inst (.clk(clk), .sys_rst(sys_rst),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
  .cmd_sub(cmd_sub), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
  .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_o(scl_o),
  .sda_o(sda_o));

// [testbench/ccm_dev.sv]
// Behavioural charge-counter slave on the two-wire bus.
// Assumes resolved line levels; a release lets the pull-up win.
`timescale 1ns/1ns
module ccm_dev (
  input wire logic scl,
  input wire logic sda,
  input wire logic mute,
  output logic sda_rel
);
  // ==========================================================
  // Registers and bus port
  // register space
  logic [7:0] pend [0:255];
  logic [7:0] live [0:255];
  logic [7:0] ptr, b;
  int nst = 0, seen = 0;
  initial sda_rel = 1'b1;
  task automatic rx();
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl);
      b[i] = sda;
    end
  endtask : rx
  task automatic ack();
    @(negedge scl);
    sda_rel = 1'b0;
    @(negedge scl);
    sda_rel = 1'b1;
  endtask : ack
  always @(negedge sda) if (scl === 1'b1) begin
    disable body;
    sda_rel = 1'b1;
    nst++;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    disable body;
    live = pend;
  end
  always begin : body
    wait (nst != seen);
    seen = nst;
    rx();
    if (b[7:1] == 7'h64 && !mute) begin
      ack();
      if (b[0]) begin
        b = live[ptr];
        for (int i = 7; i >= 0; i--) begin
          sda_rel = b[i];
          @(negedge scl);
        end
        sda_rel = 1'b1;
      end else begin
        forever begin
          rx();
          ack();
          ptr = b;
          rx();
          ack();
          pend[ptr] = b;
        end
      end
    end
  end
endmodule : ccm_dev

// [testbench/testbench.sv]
// Self-checking bench: bus master against a behavioural slave.
// Assumes a 250 MHz clock and pull-ups on both lines.
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic mute = 1'b0;
  ccm_pkg::ccm_cmd_e cmd_op = ccm_pkg::CCM_CMD_WRITE;
  logic [7:0] cmd_sub = 8'h00, cmd_data = 8'h00, s1, d1, d2, rsp_data;
  logic cmd_ready, rsp_valid, rsp_nack, scl_oe_n, sda_oe_n, sda_rel;
  logic [9:0] expq [$];
  logic [9:0] e;
  int n_errors = 0, cmp_count = 0, seed = 32'h37cd;
  wire logic scl = scl_oe_n;
  wire logic sda = sda_oe_n & sda_rel;
  always #2 clk = ~clk;
  ccm_master ccm_master_inst (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_sub(cmd_sub), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack), .scl_i(scl), .scl_o(),
    .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n));
  ccm_dev ccm_dev_inst (.scl(scl), .sda(sda), .mute(mute),
    .sda_rel(sda_rel));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic send(input ccm_pkg::ccm_cmd_e op,
    input logic [7:0] sub, dat, input logic [9:0] ex);
    @(negedge clk);
    {cmd_valid, cmd_op, cmd_sub, cmd_data} = {1'b1, op, sub, dat};
    expq.push_back(ex);
    for (int i = 0; i < 30000 && cmd_ready !== 1'b1; i++) @(negedge clk);
    if (cmd_ready !== 1'b1) n_errors++;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : send
  task automatic drain();
    for (int i = 0; i < 30000 && expq.size() != 0; i++) @(negedge clk);
    if (expq.size() != 0) n_errors++;
  endtask : drain
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // Response monitor
  always @(negedge clk) if (rsp_valid === 1'b1) begin
    e = expq.pop_front();
    chk("rsp_nack", {7'h00, rsp_nack}, {7'h00, e[8]});
    if (e[9]) chk("rsp_data", rsp_data, e[7:0]);
  end
  // ==========================================================
  // Scenarios
  initial begin
    s1 = 8'($random(seed));
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    repeat (8) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    send(ccm_pkg::CCM_CMD_WRITE, s1, d1, 10'h000);
    send(ccm_pkg::CCM_CMD_POINT, s1, 8'h00, 10'h000);
    send(ccm_pkg::CCM_CMD_READ, 8'h00, 8'h00, {2'b10, d1});
    send(ccm_pkg::CCM_CMD_WRITE, s1 ^ 8'h01, d2, 10'h000);
    send(ccm_pkg::CCM_CMD_READ, 8'h00, 8'h00, {2'b10, d2});
    drain();
    mute = 1'b1;
    send(ccm_pkg::CCM_CMD_WRITE, s1, d1, 10'h100);
    drain();
    summarize();
  end
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule : testbench
